// *** core/qcc_cfg.svh ***
// register offsets, field positions, reset values for the quadrature counter control
`ifndef QCC_CFG_SVH
`define QCC_CFG_SVH
`define QCC_OFS_CTRL     12'h000
`define QCC_OFS_POS_LO   12'h004
`define QCC_OFS_POS_HI   12'h008
`define QCC_OFS_TMR_LO   12'h00C
`define QCC_OFS_TMR_HI   12'h010
`define QCC_OFS_HOLD_HI  12'h014
`define QCC_OFS_HOLD_LO  12'h018
`define QCC_MODE_LSB     0
`define QCC_GATE_BIT     2
`define QCC_POL_BIT      3
`define QCC_PRE_LSB      4
`define QCC_SWAP_BIT     7
`define QCC_AINV_BIT     8
`define QCC_BINV_BIT     9
`define QCC_IMV_LSB      10
`define QCC_PIM_LSB      12
`define QCC_CTRL_MASK    16'h7FFF
`define QCC_CTRL_RST     16'h0000
`define QCC_HOLD_RST     16'h0000
`define QCC_PRE_ONES     7'h7F
`endif

// *** core/qcc_pkg.sv ***
// types shared by the quadrature counter control
package qcc_pkg;
  typedef enum logic [1:0] {mode_quad, mode_ext_dir, mode_ext_clk, mode_timer} counter_mode_e;
  typedef logic [15:0] word_t;
endpackage

// *** core/quadrature_counter_control.sv ***
// quadrature counter control: mode select, prescaler, position counter, interval timer, apb registers
//
// Summary of operation
// R1: three-bit prescale divides the counter clock by two to the field value.
// R2: polarity set counts down by default, clear counts up; external direction may override.
// R3: gate enable set lets the gate input stop the position counter.
// R4: mode 11 counts prescaled internal clock ticks as a timer.
// R5: mode 10 counts rising edges of the external clock input.
// R6: mode 01 counts external clock edges, direction from the direction input.
// R7: mode 00 decodes both phases x4, direction from phase order.
// R8: modes 10 and 11 act as timers and ignore the init mode field.
// R9: mode 00 clears the whole position counter on an index match.
// R10: index match uses phases after swap and inversion.
// R11: software picks a counter clock at least twice the count rate.
// R12: high hold register carries timer bits 31 to 16.
// R13: low hold register carries timer bits 15 to 0.
// R14: timer low read captures high word; low write loads held high word.
`include "qcc_cfg.svh"
module quadrature_counter_control (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // encoder pins
  input  wire logic        phase_a_input,
  input  wire logic        phase_b_input,
  input  wire logic        index_input,
  input  wire logic        count_clock_input,
  input  wire logic        up_down_input,
  input  wire logic        gate_input,
  // status
  output logic      [31:0] position_count
);
  localparam int NPIN = 6;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [15:0]     ctrl_q;
  logic [6:0]      pre_q;
  logic [6:0]      pre_mask;
  logic            tick;
  logic            qa_q;
  logic            qb_q;
  logic            eclk_q;
  logic            a_c;
  logic            b_c;
  logic            step;
  logic            down;
  logic            gate_ok;
  logic            advance;
  logic            idx_hit;
  logic [31:0]     pos_q;
  logic [31:0]     itmr_q;
  logic [15:0]     hh_q;
  logic [15:0]     hl_q;
  logic [31:0]     prdata_q;
  logic            err_q;
  logic [31:0]     rdata_d;
  logic            hit_d;
  logic            setup;
  logic            wr;
  logic [2:0]      prescale;
  logic            pol;
  logic            gate_en;
  logic [1:0]      index_match_value;
  qcc_pkg::counter_mode_e mode;

  assign pin_raw = {gate_input, up_down_input, count_clock_input,
                    index_input, phase_b_input, phase_a_input};

  // two-stage synchronisers, one per pin
  generate
    for (genvar i = 0; i < NPIN; i++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
        end
        else
        begin
          sync1_q[i] <= pin_raw[i];
          sync2_q[i] <= sync1_q[i];
        end
      end
    end
  endgenerate

  assign mode     = qcc_pkg::counter_mode_e'(ctrl_q[`QCC_MODE_LSB +: 2]);
  assign prescale = ctrl_q[`QCC_PRE_LSB +: 3];
  assign pol      = ctrl_q[`QCC_POL_BIT];
  assign gate_en  = ctrl_q[`QCC_GATE_BIT];
  assign index_match_value      = ctrl_q[`QCC_IMV_LSB +: 2];

  // prescaler: tick when the low prescale bits are all ones
  assign pre_mask = 7'(`QCC_PRE_ONES >> (3'h7 - prescale)) & {7{prescale != 3'h0}};
  assign tick     = ((pre_q & pre_mask) == pre_mask); // R1

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_q <= 7'h00;
    else
      pre_q <= 7'(pre_q + 7'h01);
  end

  // phase conditioning, swap then invert
  assign a_c = (ctrl_q[`QCC_SWAP_BIT] ? sync2_q[1] : sync2_q[0]) ^ ctrl_q[`QCC_AINV_BIT]; // R10
  assign b_c = (ctrl_q[`QCC_SWAP_BIT] ? sync2_q[0] : sync2_q[1]) ^ ctrl_q[`QCC_BINV_BIT]; // R10

  // previous samples taken at the prescaled rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      qa_q   <= 1'b0;
      qb_q   <= 1'b0;
      eclk_q <= 1'b0;
    end
    else if (tick)
    begin
      qa_q   <= a_c;
      qb_q   <= b_c;
      eclk_q <= sync2_q[3];
    end
  end

  // count step and direction per mode
  always_comb
  begin
    step = 1'b0;
    down = pol; // R2
    unique case (mode)
      qcc_pkg::mode_quad:
      begin
        // exactly one phase moved; both moving is an illegal jump
        step = (a_c ^ qa_q) ^ (b_c ^ qb_q); // R7
        down = pol ^ (qa_q ^ b_c); // R7
      end
      qcc_pkg::mode_ext_dir:
      begin
        step = sync2_q[3] & ~eclk_q; // R6
        down = pol ^ ~sync2_q[4]; // R6
      end
      qcc_pkg::mode_ext_clk:
        step = sync2_q[3] & ~eclk_q; // R5
      qcc_pkg::mode_timer:
        step = 1'b1; // R4
    endcase
  end

  assign gate_ok = ~gate_en | sync2_q[5]; // R3
  assign advance = tick & step & gate_ok;
  // index reset only in quadrature mode; timer modes ignore init mode
  assign idx_hit = (mode == qcc_pkg::mode_quad) & tick & sync2_q[2]
                   & ({b_c, a_c} == index_match_value); // R9 R8

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos_q <= 32'h0000_0000;
    else if (idx_hit)
      pos_q <= 32'h0000_0000; // R9
    else if (advance)
      pos_q <= down ? 32'(pos_q - 32'h1) : 32'(pos_q + 32'h1); // R2
  end

  assign position_count = pos_q;

  // apb decode
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & err_q;
  assign prdata  = prdata_q;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    case (paddr)
      `QCC_OFS_CTRL:    rdata_d = {16'h0000, ctrl_q};
      `QCC_OFS_POS_LO:  rdata_d = {16'h0000, pos_q[15:0]};
      `QCC_OFS_POS_HI:  rdata_d = {16'h0000, pos_q[31:16]};
      `QCC_OFS_TMR_LO:  rdata_d = {16'h0000, itmr_q[15:0]};
      `QCC_OFS_TMR_HI:  rdata_d = {16'h0000, hh_q};
      `QCC_OFS_HOLD_HI: rdata_d = {16'h0000, hh_q};
      `QCC_OFS_HOLD_LO: rdata_d = {16'h0000, hl_q};
      default:          hit_d   = 1'b0;
    endcase
  end

  // read data and error latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      err_q    <= ~hit_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `QCC_CTRL_RST;
    else if (wr && paddr == `QCC_OFS_CTRL)
      ctrl_q <= pwdata[15:0] & `QCC_CTRL_MASK;
  end

  // hold registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hh_q <= `QCC_HOLD_RST;
      hl_q <= `QCC_HOLD_RST;
    end
    else if (setup && !pwrite && paddr == `QCC_OFS_TMR_LO)
    begin
      hh_q <= itmr_q[31:16]; // R14 R12
      hl_q <= itmr_q[15:0]; // R13
    end
    else if (wr)
    begin
      if (paddr == `QCC_OFS_HOLD_HI || paddr == `QCC_OFS_TMR_HI)
        hh_q <= pwdata[15:0]; // R12
      if (paddr == `QCC_OFS_HOLD_LO || paddr == `QCC_OFS_TMR_LO)
        hl_q <= pwdata[15:0]; // R13
    end
  end

  // interval timer on the prescaled clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      itmr_q <= 32'h0000_0000;
    else if (wr && paddr == `QCC_OFS_TMR_LO)
      itmr_q <= {hh_q, pwdata[15:0]}; // R14
    else if (tick)
      itmr_q <= 32'(itmr_q + 32'h1); // R1
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tmr_lo_write;
    psel && penable && pwrite && paddr == `QCC_OFS_TMR_LO;
  endsequence

  sequence s_tmr_lo_read;
    psel && !penable && !pwrite && paddr == `QCC_OFS_TMR_LO;
  endsequence

  sequence s_free_count;
    tick && gate_ok && !idx_hit;
  endsequence

  chk_prescale_one: assert property ((prescale == 3'h0) |-> tick) // R1
    else $error("prescale 1:1 missed a tick");
  // a prescale write may land on the closing edge; only a steady 1:2 setting is checked there
  chk_prescale_two: assert property ((tick && prescale == 3'h1) ##1 (prescale == 3'h1)
    |-> !tick ##1 (tick || prescale != 3'h1)) // R1
    else $error("prescale 1:2 period wrong");
  chk_timer_down: assert property ((mode == qcc_pkg::mode_timer && pol && !wr) and s_free_count
    |=> pos_q == 32'($past(pos_q) - 32'h1)) // R2
    else $error("negative polarity did not count down");
  chk_gate_stops: assert property ((gate_en && !sync2_q[5] && !idx_hit) |=> $stable(pos_q)) // R3
    else $error("gated counter moved");
  chk_timer_up: assert property ((mode == qcc_pkg::mode_timer && !pol) and s_free_count
    |=> pos_q == 32'($past(pos_q) + 32'h1)) // R4 R8
    else $error("timer mode did not count up");
  chk_ext_no_edge: assert property ((mode == qcc_pkg::mode_ext_clk && !(sync2_q[3] && !eclk_q))
    |=> $stable(pos_q)) // R5
    else $error("external clock count without edge");
  chk_ext_dir_down: assert property ((mode == qcc_pkg::mode_ext_dir && advance && !pol && !sync2_q[4])
    |=> pos_q == 32'($past(pos_q) - 32'h1)) // R6
    else $error("direction input ignored");
  chk_quad_up: assert property ((mode == qcc_pkg::mode_quad && !pol && !qa_q && !qb_q && a_c && !b_c)
    and s_free_count |=> pos_q == 32'($past(pos_q) + 32'h1)) // R7
    else $error("quadrature up step wrong");
  chk_index_clear: assert property (idx_hit |=> pos_q == 32'h0000_0000) // R9 R10
    else $error("index match did not clear position");
  chk_hold_capture: assert property (s_tmr_lo_read |=> hh_q == $past(itmr_q[31:16])
    && hl_q == $past(itmr_q[15:0])) // R12 R13 R14
    else $error("hold capture incoherent");
  chk_timer_load: assert property (s_tmr_lo_write |=> itmr_q == {$past(hh_q), $past(pwdata[15:0])}) // R14
    else $error("timer low write did not load held high");
endmodule

// *** testbench/quad_encoder_model.sv ***
// encoder phase model driving gray-coded phase pins
module quad_encoder_model (
  // requests from the bench
  input  wire logic pclk,
  input  wire logic step,
  input  wire logic fwd,
  // phase pins
  output logic      phase_a,
  output logic      phase_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pos_q = 2'h0;
  // forward walk makes phase a lead phase b
  always_ff @(posedge pclk)
    if (step)
      pos_q <= fwd ? pos_q + 2'h1 : pos_q - 2'h1;
  assign phase_a = pos_q[1] ^ pos_q[0];
  assign phase_b = pos_q[1];
endmodule

// *** testbench/quadrature_counter_control_test.sv ***
// self-checking bench for the quadrature counter control
`include "qcc_cfg.svh"
module quadrature_counter_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, position_count, rd, p0, exp;
  logic        pha, phb, idx = 0, cclk = 0, ud = 0, gate = 0, step = 0, fwd = 0;
  int          num_errors = 0, cmp_count = 0, cyc = 0;

  always #2 pclk = ~pclk;

  quadrature_counter_control u_quadrature_counter_control (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_a_input(pha), .phase_b_input(phb), .index_input(idx),
    .count_clock_input(cclk), .up_down_input(ud), .gate_input(gate), .position_count(position_count));
  quad_encoder_model u_quad_encoder_model (.pclk(pclk), .step(step), .fwd(fwd), .phase_a(pha), .phase_b(phb));

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic sample(output logic [31:0] v);
    @(negedge pclk);
    v = position_count;
    @(posedge pclk);
  endtask

  // one count event: phase step or external clock pulse
  task automatic event_step(input logic [1:0] m, input logic d);
    fwd <= d;
    ud <= d;
    gate <= 1'($urandom);
    if (m == 2'h0)
      step <= 1'b1;
    else
      cclk <= 1'b1;
    @(posedge pclk);
    step <= 1'b0;
    repeat (4) @(posedge pclk);
    cclk <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  function automatic logic up_of(logic [1:0] m, logic pol, logic d);
    return (m == 2'h2) ? !pol : (d ^ pol);
  endfunction

  function automatic logic [1:0] cond(logic [1:0] ba, logic sw, logic ai, logic bi);
    return (sw ? {ba[0], ba[1]} : ba) ^ {bi, ai};
  endfunction

  initial
  begin
    logic [1:0]  m, cv;
    logic        pol;
    logic [15:0] h;
    int          n;
    void'($urandom(32'h06D7));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `QCC_OFS_CTRL, 0);
    check("control reset", {16'h0, `QCC_CTRL_RST}, rd);
    apb(0, `QCC_OFS_HOLD_HI, 0);
    check("hold high reset", {16'h0, `QCC_HOLD_RST}, rd);
    apb(0, `QCC_OFS_HOLD_LO, 0);
    check("hold low reset", {16'h0, `QCC_HOLD_RST}, rd);
    apb(1, 12'h01C, 32'hFFFF);
    check("unmapped error", 1, err);
    apb(0, 12'h01C, 0);
    check("unmapped read", 0, {rd[30:0], ~err});
    h = 16'($urandom);
    apb(1, `QCC_OFS_CTRL, h);
    apb(0, `QCC_OFS_CTRL, 0);
    check("control", {16'h0, h & `QCC_CTRL_MASK}, rd);
    check("control error", 0, err);
    for (int k = 0; k < 6; k++)
    begin
      m = k[2:1];
      pol = k[0];
      apb(1, `QCC_OFS_CTRL, {1'b0, 3'($urandom), 8'h00, pol, 1'b0, m});
      repeat (4) @(posedge pclk);
      sample(exp);
      repeat ($urandom_range(3, 12))
      begin
        n = $urandom_range(0, 1);
        event_step(m, n[0]);
        exp = up_of(m, pol, n[0]) ? exp + 1 : exp - 1;
      end
      sample(rd);
      check("position", exp, rd);
      apb(0, `QCC_OFS_POS_LO, 0);
      check("position low", {16'h0, exp[15:0]}, rd);
      apb(0, `QCC_OFS_POS_HI, 0);
      check("position high", {16'h0, exp[31:16]}, rd);
    end
    gate <= 1'b0;
    apb(1, `QCC_OFS_CTRL, 16'h0007);
    repeat (6) @(posedge pclk);
    sample(p0);
    repeat (20) @(posedge pclk);
    sample(rd);
    check("gated position", p0, rd);
    gate <= 1'b1;
    repeat (20) @(posedge pclk);
    sample(rd);
    check("ungated moves", 1, rd !== p0);
    for (int p = 0; p < 8; p++)
    begin
      apb(1, `QCC_OFS_CTRL, {9'h000, p[2:0], p[0], 3'h3});
      sample(p0);
      n = 0;
      do
        sample(rd);
      while (rd === p0 && ++n < 300);
      p0 = rd;
      n = 0;
      do
        sample(rd);
      while (rd === p0 && ++n < 300);
      check("tick period", 32'(1 << p), 32'(n + 1));
      check("timer step", p[0] ? p0 - 32'h1 : p0 + 32'h1, rd);
    end
    for (int j = 0; j < 2; j++)
    begin
      apb(1, `QCC_OFS_CTRL, 0);
      event_step(2'h0, 1'b1);
      event_step(2'h0, 1'b1);
      cv = cond({phb, pha}, 1'b1, 1'b1, 1'b0) ^ 2'(1 - j);
      apb(1, `QCC_OFS_CTRL, {4'h0, cv, 3'b011, 7'h00});
      repeat (4) @(posedge pclk);
      sample(p0);
      idx <= 1'b1;
      repeat (6) @(posedge pclk);
      idx <= 1'b0;
      sample(rd);
      check("index clear", j ? 32'h0 : p0, rd);
    end
    h = 16'($urandom);
    apb(1, `QCC_OFS_CTRL, 16'h0073);
    apb(1, `QCC_OFS_HOLD_HI, h);
    apb(1, `QCC_OFS_TMR_LO, 16'hFFFF);
    apb(0, `QCC_OFS_TMR_LO, 0);
    p0 = rd;
    apb(0, `QCC_OFS_HOLD_HI, 0);
    exp = {rd[15:0], p0[15:0]};
    check("timer coherent", 1, exp === {h, 16'hFFFF} || exp === {h + 16'h1, 16'h0});
    apb(0, `QCC_OFS_TMR_HI, 0);
    check("timer high", {16'h0, exp[31:16]}, rd);
    apb(0, `QCC_OFS_HOLD_LO, 0);
    check("hold low", p0, rd);
    conclude();
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
endmodule
